/* File: pswd_pkg.sv */
// Shared constants for the power-state, self-test and supervision timer block.
// Assumes a 250 MHz core clock and a register write port decoded upstream.
package pswd_pkg;
  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned POR_FILT_NS = 1000;
  localparam int unsigned POR_FILT_CYC = (POR_FILT_NS + 3) / 4;
  localparam int unsigned RST_PULSE_US = 10;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * 1000 / 4;
  // ==========================================================
  // Register addresses (local write/read port)
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_WD_CFG = 3'h1;
  localparam logic [2:0] ADDR_WD_CTL = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  // ==========================================================
  // Field positions
  localparam int CTRL1_HOLD_BIT = 0;
  localparam int CTRL1_PROT_EN_BIT = 1;
  localparam int CTRL1_SELFTEST_BIT = 6;
  localparam int WD_EN_BIT = 7;
  localparam int WD_X1S_BIT = 6;
  localparam int WD_X100_BIT = 5;
  localparam int WD_X10_BIT = 4;
  localparam int WD_REFRESH_BIT = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h02;
  localparam logic [7:0] WD_CFG_RST = 8'hca;
  localparam logic [7:0] WD_CTL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  // ==========================================================
  // Operating states, Gray along sleep -> normal -> shutdown
  typedef enum logic [1:0] {
    PS_SLEEP = 2'b00,
    PS_NORMAL = 2'b01,
    PS_PREP_SHDN = 2'b11
  } pswd_state_t;
endpackage

/* File: pswd_por_filter.sv */
// Key switch filter: a level must hold for a set time before it is passed.
// Assumes the key switch input is synchronous to i_clk.
`timescale 1ns/10ps
module pswd_por_filter
  import pswd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw and filtered key level
  input wire logic i_key,
  output logic o_key_filt
);
  // ==========================================================
  // Stability counter
  logic [15:0] cnt_r, cnt_nxt;
  logic filt_r, filt_nxt;

  always_comb begin
    cnt_nxt = 16'h0000;
    filt_nxt = filt_r;
    if (i_key != filt_r) begin
      // Short transients restart the count and never reach the output
      if (cnt_r == 16'(POR_FILT_CYC - 1)) begin
        filt_nxt = i_key;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
      filt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign o_key_filt = filt_r;
endmodule

/* File: pswd_wd_timer.sv */
// Supervision timer: counts 1 ms ticks down from a decoded interval.
// Assumes the load strobe is a one-cycle pulse from the register block.
`timescale 1ns/10ps
module pswd_wd_timer
  import pswd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_enable,
  input wire logic i_load,
  input wire logic [6:0] i_interval,
  // Timeout event
  output logic o_expire
);
  // ==========================================================
  // Interval decode: count 1..10 times unit in ms
  logic [3:0] count;
  logic [13:0] ms;
  always_comb begin
    if (i_interval[3:0] == 4'h0) begin
      count = 4'h1;
    end else if (i_interval[3:0] > 4'ha) begin
      count = 4'ha;
    end else begin
      count = i_interval[3:0];
    end
    if (i_interval[WD_X1S_BIT]) begin
      ms = 14'(count) * 14'h03e8;
    end else if (i_interval[WD_X100_BIT]) begin
      ms = 14'(count) * 14'h0064;
    end else if (i_interval[WD_X10_BIT]) begin
      ms = 14'(count) * 14'h000a;
    end else begin
      ms = 14'(count);
    end
  end

  // ==========================================================
  // Tick prescaler and millisecond counter
  logic [17:0] pre_r, pre_nxt;
  logic [13:0] ms_r, ms_nxt;
  logic exp_r, exp_nxt;

  always_comb begin
    pre_nxt = pre_r;
    ms_nxt = ms_r;
    exp_nxt = 1'b0;
    if (i_load) begin
      pre_nxt = 18'h00000;
      ms_nxt = ms;
    end else if (!i_enable) begin
      pre_nxt = 18'h00000;
    end else if (pre_r == 18'(TICK_CYC - 1)) begin
      pre_nxt = 18'h00000;
      if (ms_r <= 14'h0001) begin
        exp_nxt = 1'b1;
        ms_nxt = ms;
      end else begin
        ms_nxt = ms_r - 14'h0001;
      end
    end else begin
      pre_nxt = pre_r + 18'h00001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_r <= 18'h00000;
      ms_r <= 14'h2710;
      exp_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      ms_r <= ms_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign o_expire = exp_r;
endmodule

/* File: pswd_top.sv */
// Power-state control, self-test status access and supervision timer.
// Assumes a decoded byte-wide register port from the serial interface.
// Internal soft resets reuse the flip-flop reset values.
`timescale 1ns/10ps
module pswd_top
  import pswd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins
  input wire logic i_key_switch_input,
  input wire logic i_supply_ok,
  input wire logic [7:0] i_fault_set,
  // Register port
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Power control
  output logic o_battery_switch_output,
  output logic o_supplies_on,
  output logic o_outputs_enable,
  output logic o_protected_sensor_supply,
  output pswd_pkg::pswd_state_t o_state,
  // MCU reset, open drain: drive low when oe low
  output logic o_mcu_reset_output_out,
  output logic o_mcu_reset_output_oe_n
);
  import pswd_pkg::*;

  // ==========================================================
  // Key filter and power-on reset generation
  logic key_filt;
  logic key_q_r, key_q_nxt;
  logic por_pulse;

  // Filtering before edge detection keeps glitches off the reset
  pswd_por_filter u_filt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_key(i_key_switch_input),
    .o_key_filt(key_filt)
  );

  // Previous filtered level, for the rising-edge detect
  always_comb begin
    key_q_nxt = key_filt;
  end

  // Filtered rise with supply present reinitialises the block
  assign por_pulse = key_filt && !key_q_r && i_supply_ok;

  // ==========================================================
  // Registers
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] wd_cfg_r, wd_cfg_nxt;
  logic [7:0] wd_ctl_r, wd_ctl_nxt;
  logic [7:0] stat_r, stat_nxt;
  // Timer hooks
  logic wd_expire;
  logic wd_load;
  logic [6:0] wd_interval;
  logic soft_rst;
  logic selftest;
  logic wr_ctrl1, wr_cfg, wr_ctl, wr_stat;

  // ==========================================================
  // Write decode
  // Unused addresses are ignored on write and read back zero
  assign wr_ctrl1 = i_wr && (i_addr == ADDR_CTRL1);
  assign wr_cfg = i_wr && (i_addr == ADDR_WD_CFG);
  assign wr_ctl = i_wr && (i_addr == ADDR_WD_CTL);
  assign wr_stat = i_wr && (i_addr == ADDR_STAT);
  assign soft_rst = por_pulse || wd_expire;
  assign selftest = ctrl1_r[CTRL1_SELFTEST_BIT];

  // ==========================================================
  // Refresh and interval select
  assign wd_load = wr_ctl && i_wdata[WD_REFRESH_BIT];

  // One-shot value in the write, else one stored earlier, else config
  always_comb begin
    if (i_wdata[6:0] != 7'h00) begin
      wd_interval = i_wdata[6:0];
    end else if (wd_ctl_r[6:0] != 7'h00) begin
      wd_interval = wd_ctl_r[6:0];
    end else begin
      wd_interval = wd_cfg_r[6:0];
    end
  end

  // ==========================================================
  // Register next values
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    wd_cfg_nxt = wd_cfg_r;
    wd_ctl_nxt = wd_ctl_r;
    stat_nxt = stat_r;
    if (wr_ctrl1) begin
      ctrl1_nxt = i_wdata;
    end
    if (wr_cfg) begin
      wd_cfg_nxt = i_wdata;
    end
    if (wr_ctl) begin
      // Writes without refresh keep a one-shot value for later
      wd_ctl_nxt = i_wdata;
    end
    if (wd_load) begin
      wd_ctl_nxt = WD_CTL_RST;
    end
    if (selftest) begin
      // Self-test isolates status from the fault inputs
      if (wr_stat) begin
        stat_nxt = i_wdata;
      end
    end else begin
      if (wr_stat) begin
        stat_nxt = stat_r & i_wdata;
      end
      // Fault set beats a host clear in the same cycle
      stat_nxt = stat_nxt | i_fault_set;
    end
    // Leaving self-test wipes whatever patterns the host left
    if (wr_ctrl1 && selftest && !i_wdata[CTRL1_SELFTEST_BIT]) begin
      stat_nxt = STAT_RST;
    end
    if (soft_rst) begin
      // Timer reset also drops self-test, guarding hung test loops
      ctrl1_nxt = CTRL1_RST;
      wd_cfg_nxt = WD_CFG_RST;
      wd_ctl_nxt = WD_CTL_RST;
      stat_nxt = STAT_RST;
    end
  end

  // Same defaults as the internal soft reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      key_q_r <= 1'b0;
      ctrl1_r <= CTRL1_RST;
      wd_cfg_r <= WD_CFG_RST;
      wd_ctl_r <= WD_CTL_RST;
      stat_r <= STAT_RST;
    end else begin
      key_q_r <= key_q_nxt;
      ctrl1_r <= ctrl1_nxt;
      wd_cfg_r <= wd_cfg_nxt;
      wd_ctl_r <= wd_ctl_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ==========================================================
  // Supervision timer
  // Any soft reset restarts the timer at the default interval
  pswd_wd_timer u_wd (
    .i_clk(i_clk),
    .i_rst(i_rst || soft_rst),
    .i_enable(wd_cfg_r[WD_EN_BIT]),
    .i_load(wd_load),
    .i_interval(wd_interval),
    .o_expire(wd_expire)
  );

  // ==========================================================
  // Reset pulse stretcher
  // Counter and pin enable share one register group
  logic [11:0] rp_cnt_r, rp_cnt_nxt;
  logic rst_oe_n_r, rst_oe_n_nxt;
  always_comb begin
    rp_cnt_nxt = rp_cnt_r;
    // Soft resets restart a pulse already running
    if (soft_rst) begin
      rp_cnt_nxt = 12'(RST_PULSE_CYC);
    end else if (rp_cnt_r != 12'h000) begin
      rp_cnt_nxt = rp_cnt_r - 12'h001;
    end
    // Pin released only once the count has run out
    rst_oe_n_nxt = (rp_cnt_nxt == 12'h000);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rp_cnt_r <= 12'(RST_PULSE_CYC);
      rst_oe_n_r <= 1'b0;
    end else begin
      rp_cnt_r <= rp_cnt_nxt;
      rst_oe_n_r <= rst_oe_n_nxt;
    end
  end

  // Open drain: the data side is always low
  assign o_mcu_reset_output_out = 1'b0;
  assign o_mcu_reset_output_oe_n = rst_oe_n_r;

  // ==========================================================
  // Operating state
  // Hold bit keeps the rails up after the key drops
  pswd_state_t st_r, st_nxt;
  always_comb begin
    case ({key_filt, ctrl1_r[CTRL1_HOLD_BIT]})
      2'b00: st_nxt = PS_SLEEP;
      2'b01: st_nxt = PS_PREP_SHDN;
      2'b10: st_nxt = PS_NORMAL;
      2'b11: st_nxt = PS_NORMAL;
      default: st_nxt = PS_SLEEP;
    endcase
  end

  // Outputs below follow the same next state, so they never lag it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= PS_SLEEP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Output stage
  logic bat_r, sup_r, out_r, prot_r;
  logic bat_nxt, sup_nxt, out_nxt, prot_nxt;
  always_comb begin
    bat_nxt = (st_nxt == PS_NORMAL);
    sup_nxt = (st_nxt != PS_SLEEP);
    // Outputs stay off in sleep and while the MCU is held in reset
    out_nxt = (st_nxt == PS_NORMAL) && (rp_cnt_nxt == 12'h000);
    // Sensor supply needs the rails up and its enable bit
    prot_nxt = sup_nxt && ctrl1_nxt[CTRL1_PROT_EN_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bat_r <= 1'b0;
      sup_r <= 1'b0;
      out_r <= 1'b0;
      prot_r <= 1'b0;
    end else begin
      bat_r <= bat_nxt;
      sup_r <= sup_nxt;
      out_r <= out_nxt;
      prot_r <= prot_nxt;
    end
  end

  assign o_battery_switch_output = bat_r;
  assign o_supplies_on = sup_r;
  assign o_outputs_enable = out_r;
  assign o_protected_sensor_supply = prot_r;
  assign o_state = st_r;

  // ==========================================================
  // Read-back mux
  // Reads have no side effects on any register
  // Registered so read data stands for a full cycle
  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    case (i_addr)
      ADDR_CTRL1: rdata_nxt = ctrl1_r;
      ADDR_WD_CFG: rdata_nxt = wd_cfg_r;
      ADDR_WD_CTL: rdata_nxt = wd_ctl_r;
      ADDR_STAT: rdata_nxt = stat_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
endmodule

/* File: pswd_assertions.sv */
// Port checker for pswd_top.
// Bound into every pswd_top; sees its ports only.
`timescale 1ns/10ps
module pswd_assertions
  import pswd_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_key_switch_input,
  input wire logic i_supply_ok,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_battery_switch_output,
  input wire logic o_supplies_on,
  input wire logic o_outputs_enable,
  input wire logic o_protected_sensor_supply,
  input wire pswd_state_t o_state,
  input wire logic o_mcu_reset_output_out,
  input wire logic o_mcu_reset_output_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ====
  // Reset pulse length counter
  int low_r;
  int low_nxt;
  always_comb begin
    low_nxt = o_mcu_reset_output_oe_n ? 0 : low_r + 1;
  end
  always_ff @(posedge i_clk) begin
    low_r <= i_rst ? 0 : low_nxt;
  end
  sequence s_refresh;
    i_wr && i_addr == ADDR_WD_CTL && i_wdata[WD_REFRESH_BIT]
      ##1 !i_wr && i_addr == ADDR_WD_CTL;
  endsequence
  sequence s_cfg_wr;
    i_wr && i_addr == ADDR_WD_CFG ##1 !i_wr && i_addr == ADDR_WD_CFG;
  endsequence
  sequence s_wake;
    o_state == PS_SLEEP && i_supply_ok ##1 o_state == PS_NORMAL;
  endsequence
  AST_SLEEP_OFF: assert property (o_state == PS_SLEEP |->
    !o_battery_switch_output && !o_supplies_on && !o_outputs_enable)
    else $error("outputs on in sleep");
  AST_NORMAL: assert property (o_state == PS_NORMAL |->
    o_battery_switch_output && o_supplies_on)
    else $error("normal state outputs");
  AST_PREP: assert property (o_state == PS_PREP_SHDN |->
    !o_battery_switch_output && o_supplies_on)
    else $error("shutdown state outputs");
  AST_PROT: assert property (o_protected_sensor_supply |-> o_supplies_on)
    else $error("sensor supply without supplies");
  AST_PIN_LOW: assert property (o_mcu_reset_output_out == 1'b0)
    else $error("reset pin drives high");
  AST_PULSE: assert property ($rose(o_mcu_reset_output_oe_n) |->
    low_r inside {[RST_PULSE_CYC-2:RST_PULSE_CYC+2]})
    else $error("reset pulse length");
  AST_KEY_FILT: assert property ((o_state == PS_SLEEP &&
    !i_key_switch_input) |=> o_state == PS_SLEEP)
    else $error("left sleep with key low");
  AST_POR: assert property (s_wake |-> ##[0:3] !o_mcu_reset_output_oe_n)
    else $error("no reset on wake");
  AST_CTL_CLR: assert property (s_refresh |=> o_rdata == 8'h00)
    else $error("control not cleared");
  AST_CFG_RB: assert property (s_cfg_wr |=> o_rdata == $past(i_wdata, 2))
    else $error("config readback");
endmodule
bind pswd_top pswd_assertions u_pswd_assertions (.*);

/* File: pswd_host_model.sv */
// Host controller model: byte register writes and reads.
// Drives on falling edges; reset pin has an external pull-up.
`timescale 1ns/10ps
module pswd_host_model (
  // Clock
  input wire logic i_clk,
  // Register port
  output logic o_wr,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  // Reset pin
  input wire logic i_reset_oe_n,
  output logic o_reset_pin
);
  // ====
  // Port idle
  initial begin
    o_wr = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  // Pull-up wins once the drain lets go
  assign o_reset_pin = i_reset_oe_n;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

/* File: pswd_top_tb.sv */
// Self-checking bench for pswd_top with a host model.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/10ps
module pswd_top_tb;
  import pswd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic key = 1'b0;
  logic supply = 1'b1;
  logic [7:0] fault = 8'h00;
  logic wr, bat, sup, outen, prot, pin_out, oe_n, pin;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  pswd_state_t st;
  int bad_count = 0;
  int samples_checked = 0;
  always #2 i_clk = ~i_clk;
  pswd_top u_pswd_top (.i_clk(i_clk), .i_rst(i_rst),
    .i_key_switch_input(key), .i_supply_ok(supply), .i_fault_set(fault),
    .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_battery_switch_output(bat), .o_supplies_on(sup),
    .o_outputs_enable(outen), .o_protected_sensor_supply(prot),
    .o_state(st), .o_mcu_reset_output_out(pin_out),
    .o_mcu_reset_output_oe_n(oe_n));
  pswd_host_model u_pswd_host_model (.i_clk(i_clk), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
    .i_reset_oe_n(oe_n), .o_reset_pin(pin));
  // ====
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] d);
    u_pswd_host_model.wr(a, d);
  endtask
  task automatic rc(input string n, input logic [2:0] a, logic [7:0] e);
    logic [7:0] d;
    u_pswd_host_model.rd(a, d);
    chk(n, e, d);
  endtask
  // Packed as state, battery, supplies, outputs, sensor supply
  task automatic pins(input string n, input logic [7:0] e);
    repeat (3) @(negedge i_clk);
    chk(n, e, {2'b00, st, bat, sup, outen, prot});
  endtask
  task automatic until_oe(input logic v, input int lim, output int n);
    n = 0;
    while (oe_n !== v && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    pins("pins", 8'h00);
    chk("pin", 8'h00, {7'h0, pin});
    chk("pin drive", 8'h00, {7'h0, pin_out});
    rc("ctrl1", ADDR_CTRL1, 8'h02);
    rc("cfg", ADDR_WD_CFG, 8'hca);
    rc("ctl", ADDR_WD_CTL, 8'h00);
    rc("stat", ADDR_STAT, 8'h00);
  endtask
  task automatic t_power;
    int n;
    until_oe(1'b1, 3000, n);
    key = 1'b1;
    repeat (100) @(negedge i_clk);
    key = 1'b0;
    repeat (400) @(negedge i_clk);
    pins("glitch", 8'h00);
    key = 1'b1;
    until_oe(1'b0, 400, n);
    chk("por", 8'h01, {7'h0, n < 400});
    pins("normal", 8'h1d);
    until_oe(1'b1, 3000, n);
    pins("outen", 8'h1f);
  endtask
  task automatic t_states;
    w(ADDR_CTRL1, 8'h03);
    key = 1'b0;
    repeat (300) @(negedge i_clk);
    pins("prep", 8'h35);
    w(ADDR_CTRL1, 8'h01);
    pins("prot off", 8'h34);
    w(ADDR_CTRL1, 8'h00);
    pins("sleep", 8'h00);
    supply = 1'b0;
    key = 1'b1;
    repeat (300) @(negedge i_clk);
    chk("no supply", 8'h01, {7'h0, oe_n});
    key = 1'b0;
    repeat (300) @(negedge i_clk);
    supply = 1'b1;
    key = 1'b1;
    repeat (300) @(negedge i_clk);
    pins("wake", 8'h1d);
    rc("ctrl1", ADDR_CTRL1, 8'h02);
  endtask
  task automatic t_status;
    fault = 8'h05;
    @(negedge i_clk);
    fault = 8'h00;
    rc("fault", ADDR_STAT, 8'h05);
    w(ADDR_STAT, 8'hfb);
    rc("clear", ADDR_STAT, 8'h01);
    w(ADDR_CTRL1, 8'h42);
    fault = 8'h02;
    w(ADDR_STAT, 8'ha4);
    rc("selftest", ADDR_STAT, 8'ha4);
    fault = 8'h00;
    w(ADDR_CTRL1, 8'h02);
    rc("exit", ADDR_STAT, 8'h00);
  endtask
  task automatic t_wd;
    int n;
    until_oe(1'b1, 3000, n);
    w(ADDR_WD_CFG, 8'h82);
    rc("cfg", ADDR_WD_CFG, 8'h82);
    w(ADDR_CTRL1, 8'h42);
    w(ADDR_WD_CTL, 8'h01);
    rc("ctl temp", ADDR_WD_CTL, 8'h01);
    w(ADDR_WD_CTL, 8'h81);
    rc("ctl", ADDR_WD_CTL, 8'h00);
    until_oe(1'b0, 260000, n);
    chk("1ms", 8'h01, {7'h0, n > 248000 && n < 252000});
    rc("self_test_mode", ADDR_CTRL1, 8'h02);
    rc("cfg dflt", ADDR_WD_CFG, 8'hca);
  endtask
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run is near 1.04 ms of simulated time
  initial begin
    #2_000_000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    t_reset();
    t_power();
    t_states();
    t_status();
    t_wd();
    complete_run();
  end
endmodule
